/* sdrc_core.sv */
// Two stereo dynamic range control processors with source mixers
//
// Summary of operation
// - Four-source mixer with volume per input channel
// - Each processor drives two selectable output samples
// - Source-select fields pick mixer input signals
// - Processing runs from 8 kHz to 96 kHz
// - Processor one left/right enables, reset off
// - Processor two left/right enables, reset off
// - Upper slope above knee, lower below
// - First knee set by input, output dB
// - Slope one constant gain, below one compresses
// - Gate region expands below second knee
// - Expansion slope above one steepens output
// - Gate off: lower slope below first knee
// - Second knee output enable drops curve vertically
// - Without it, second knee ends lower region
// - Zero dB output from knee and slope
// - Signal detect per processor for interrupt, GPIO
// - Only processor one starts the write sequencer
// - Mixer registers at 8C0h to 8DFh
// - Read-only status of actually enabled channels
`timescale 1ns/1ps

module sdrc_core #(
    parameter int NUM_SRC  = 16,
    parameter int DEPTH    = 2,
    parameter int DIV_BASE = sdrc_pkg::DIV_BASE
) (
    input  wire logic                                          sys_clk,
    input  wire logic                                          rst_n,
    input  wire logic                                          ce,
    input  wire logic [15:0]                                   reg_addr,
    input  wire logic [15:0]                                   reg_wdata,
    input  wire logic                                          reg_wr,
    input  wire logic                                          reg_rd,
    output logic [15:0]                                        reg_rdata,
    input  wire sdrc_pkg::sdrc_rate_e                          effects_sample_rate,
    input  wire logic [NUM_SRC-1:0][sdrc_pkg::SAMPLE_W-1:0]    src_samples,
    output logic [sdrc_pkg::NUM_CH-1:0][sdrc_pkg::SAMPLE_W-1:0] out_samples,
    output logic                                               out_valid,
    input  wire logic                                          out_ready,
    output logic [1:0]                                         sig_detect,
    output logic                                               wseq_start
);
    import sdrc_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [NUM_CH-1:0][NUM_PATH-1:0][VOL_W-1:0] vol;
        logic [NUM_CH-1:0][NUM_PATH-1:0][SEL_W-1:0] sel;
        sdrc_curve_s [1:0]                          curve;
        logic [NUM_CH-1:0]                          en;
        logic                                       wseq_en;
        logic [23:0]                                div_cnt;
        logic                                       pending;
        logic [DEPTH-1:0][FRAME_W-1:0]              slot;
        logic [CNT_W-1:0]                           cnt;
        logic                                       valid;
        logic [1:0]                                 det;
        logic                                       wseq;
        logic [15:0]                                rdata;
    } sdrc_state_s;

    sdrc_state_s state_reg;
    sdrc_state_s state_next;

    // Level in whole dB from the position of the leading one
    function automatic logic signed [15:0] level_db(input logic signed [15:0] s);
        logic [15:0]        mag;
        logic signed [15:0] lvl;
        mag = s[15] ? 16'(-s) : 16'(s);
        lvl = 16'(SILENT_DB);
        for (int b = 0; b < 16; b++) begin
            if (mag[b]) begin
                lvl = 16'((b - 15) * DB_PER_BIT);
            end
        end
        return lvl;
    endfunction : level_db

    // Level difference times an unsigned fixed-point slope
    function automatic logic signed [15:0] slope_mul(input logic signed [15:0] d,
        input logic [SLOPE_W-1:0] k);
        logic signed [22:0] p;
        p = 23'(d * $signed({1'b0, k}));
        return 16'(p >>> SLOPE_FRAC);
    endfunction : slope_mul

    function automatic logic signed [15:0] sx8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sx8

    // Static curve: gain in dB to apply for an input level x
    function automatic logic signed [15:0] curve_gain(input logic signed [15:0] x,
        input sdrc_curve_s c);
        logic signed [15:0] kip;
        logic signed [15:0] kop;
        logic signed [15:0] k2ip;
        logic signed [15:0] y0;
        logic signed [15:0] yk2;
        logic signed [15:0] y;
        kip  = sx8(c.knee_ip);
        kop  = sx8(c.knee_op);
        k2ip = sx8(c.knee2_ip);
        y0   = kop - slope_mul(kip, c.hi_slope);
        if (x >= kip) begin
            y = y0 + slope_mul(x, c.hi_slope);
        end else if (!c.gate_en || x >= k2ip) begin
            y = kop + slope_mul(x - kip, c.lo_slope);
        end else begin
            // Knee2 level: own output level, else end of lower region
            yk2 = c.knee2_op_en ? sx8(c.knee2_op)
                                : kop + slope_mul(k2ip - kip, c.lo_slope);
            y = yk2 + slope_mul(x - k2ip, c.exp_slope);
        end
        return y - x;
    endfunction : curve_gain

    // Gain applied in 6 dB steps; finer steps would need a multiplier per channel
    function automatic logic [15:0] apply_gain(input logic signed [15:0] s,
        input logic signed [15:0] g);
        logic signed [15:0] gl;
        logic signed [47:0] w;
        int                 sh;
        gl = g;
        if (gl > 16'(GAIN_LIMIT_DB)) begin
            gl = 16'(GAIN_LIMIT_DB);
        end
        if (gl < 16'(-GAIN_LIMIT_DB)) begin
            gl = 16'(-GAIN_LIMIT_DB);
        end
        sh = int'(gl) / DB_PER_BIT;
        w = 48'(s);
        w = (sh >= 0) ? (w <<< sh) : (w >>> (-sh));
        if (w > 48'sd32767) begin
            w = 48'sd32767;
        end
        if (w < -48'sd32768) begin
            w = -48'sd32768;
        end
        return w[15:0];
    endfunction : apply_gain

    // Sample period divider for each effects rate
    function automatic logic [23:0] period_div(input sdrc_rate_e r);
        int m;
        unique case (r)
            SDRC_RATE_8K:   m = 1;
            SDRC_RATE_16K:  m = 2;
            SDRC_RATE_32K:  m = 4;
            SDRC_RATE_48K:  m = 6;
            SDRC_RATE_96K:  m = 12;
            SDRC_RATE_192K: m = 24;
            default:        m = 1;
        endcase
        return 24'(DIV_BASE / m - 1);
    endfunction : period_div

    // Next state: registers, pacing, mixing, curve, buffer
    always_comb begin
        logic               run_ok;
        logic [NUM_CH-1:0]  act;
        logic               tick;
        logic               push;
        logic               pop;
        logic [CNT_W-1:0]   cnt_after;
        logic [1:0]         det_now;
        logic [FRAME_W-1:0] frame;
        logic signed [31:0] acc;
        logic signed [15:0] mixed;
        logic signed [15:0] lvl;
        logic [4:0]         mi;
        logic [15:0]        rd;
        logic [15:0]        ofs;
        int                 p;
        int                 si;
        state_next = state_reg;
        run_ok     = (effects_sample_rate <= SDRC_RATE_96K);
        act        = state_reg.en & {NUM_CH{run_ok}};
        tick       = 1'b0;
        push       = 1'b0;
        det_now    = 2'b00;
        frame      = '0;
        acc        = '0;
        mixed      = '0;
        lvl        = '0;
        mi         = reg_addr[4:0] - ADDR_MIX_FIRST[4:0];
        rd         = '0;
        ofs        = '0;
        pop        = 1'b0;
        cnt_after  = '0;
        p          = 0;
        si         = 0;

        // One evaluation per sample period of the shared rate
        if (state_reg.div_cnt == '0) begin
            tick = 1'b1;
            state_next.div_cnt = period_div(effects_sample_rate);
        end else begin
            state_next.div_cnt = state_reg.div_cnt - 24'h000001;
        end

        // Four mixers, one per processor input channel
        for (int ch = 0; ch < NUM_CH; ch++) begin
            p   = ch / 2;
            acc = '0;
            for (int k = 0; k < NUM_PATH; k++) begin
                si = int'(state_reg.sel[ch][k]);
                if (si != 0 && si <= NUM_SRC) begin
                    acc = acc + 32'($signed(src_samples[si-1])
                * $signed({1'b0, state_reg.vol[ch][k]}));
                end
            end
            acc = acc >>> VOL_FRAC;
            if (acc > 32'sd32767) begin
                acc = 32'sd32767;
            end
            if (acc < -32'sd32768) begin
                acc = -32'sd32768;
            end
            mixed = acc[15:0];
            lvl   = level_db(mixed);
            if (act[ch]) begin
                frame[ch*SAMPLE_W +: SAMPLE_W] =
                    apply_gain(mixed, curve_gain(lvl, state_reg.curve[p]));
                if (lvl >= 16'(DETECT_DB)) begin
                    det_now[p] = 1'b1;
                end
            end
        end

        // Buffer drain; a missed tick waits in pending while both slots are full, and its frame is mixed when pushed
        pop       = state_reg.valid && out_ready;
        cnt_after = state_reg.cnt - CNT_W'(pop);
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                state_next.slot[i] = state_reg.slot[i+1];
            end
        end
        if ((tick || state_reg.pending) && state_reg.cnt < CNT_W'(DEPTH)) begin
            push = 1'b1;
            state_next.slot[cnt_after] = frame;
        end
        state_next.pending = (tick || state_reg.pending) && !push;
        state_next.cnt     = cnt_after + CNT_W'(push);
        state_next.valid   = (state_next.cnt != '0);

        // Detect flags follow each evaluated frame
        state_next.wseq = 1'b0;
        if (push) begin
            state_next.det  = det_now;
            state_next.wseq = det_now[0] && !state_reg.det[0] && state_reg.wseq_en;
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr >= ADDR_MIX_FIRST && reg_addr <= ADDR_MIX_LAST) begin
                if (mi[0]) begin
                    state_next.sel[mi[4:3]][mi[2:1]] = reg_wdata[SEL_W-1:0];
                end else begin
                    state_next.vol[mi[4:3]][mi[2:1]] = reg_wdata[VOL_W-1:0];
                end
            end
            for (int q = 0; q < 2; q++) begin
                ofs = reg_addr - (q == 0 ? ADDR_P1_CTRL_A : ADDR_P2_CTRL_A);
                if (ofs == 16'h0000) begin
                    state_next.en[2*q]   = reg_wdata[BIT_LEFT_EN];
                    state_next.en[2*q+1] = reg_wdata[BIT_RIGHT_EN];
                    state_next.curve[q].gate_en     = reg_wdata[BIT_GATE_EN];
                    state_next.curve[q].knee2_op_en = reg_wdata[BIT_KNEE2_OP_EN];
                    if (q == 0) begin
                        state_next.wseq_en = reg_wdata[BIT_WSEQ_EN];
                    end
                end
                if (ofs == OFS_KNEE1) begin
                    state_next.curve[q].knee_ip = reg_wdata[15:8];
                    state_next.curve[q].knee_op = reg_wdata[7:0];
                end
                if (ofs == OFS_SLOPES) begin
                    state_next.curve[q].hi_slope = reg_wdata[11:6];
                    state_next.curve[q].lo_slope = reg_wdata[5:0];
                end
                if (ofs == OFS_KNEE2) begin
                    state_next.curve[q].knee2_ip = reg_wdata[15:8];
                    state_next.curve[q].knee2_op = reg_wdata[7:0];
                end
                if (ofs == OFS_EXPAND) begin
                    state_next.curve[q].exp_slope = reg_wdata[5:0];
                end
            end
        end

        // Register reads; unmapped addresses return zero
        if (reg_rd) begin
            if (reg_addr >= ADDR_MIX_FIRST && reg_addr <= ADDR_MIX_LAST) begin
                rd = mi[0] ? 16'(state_reg.sel[mi[4:3]][mi[2:1]])
                           : 16'(state_reg.vol[mi[4:3]][mi[2:1]]);
            end
            if (reg_addr == ADDR_FX_STATUS) begin
                rd[STS_LSB +: NUM_CH] = act;
            end
            for (int q = 0; q < 2; q++) begin
                ofs = reg_addr - (q == 0 ? ADDR_P1_CTRL_A : ADDR_P2_CTRL_A);
                if (ofs == 16'h0000) begin
                    rd[BIT_LEFT_EN]     = state_reg.en[2*q];
                    rd[BIT_RIGHT_EN]    = state_reg.en[2*q+1];
                    rd[BIT_GATE_EN]     = state_reg.curve[q].gate_en;
                    rd[BIT_KNEE2_OP_EN] = state_reg.curve[q].knee2_op_en;
                    rd[BIT_WSEQ_EN]     = (q == 0) ? state_reg.wseq_en : 1'b0;
                end
                if (ofs == OFS_KNEE1) begin
                    rd = {state_reg.curve[q].knee_ip, state_reg.curve[q].knee_op};
                end
                if (ofs == OFS_SLOPES) begin
                    rd = {4'h0, state_reg.curve[q].hi_slope, state_reg.curve[q].lo_slope};
                end
                if (ofs == OFS_KNEE2) begin
                    rd = {state_reg.curve[q].knee2_ip, state_reg.curve[q].knee2_op};
                end
                if (ofs == OFS_EXPAND) begin
                    rd = {10'h000, state_reg.curve[q].exp_slope};
                end
            end
            state_next.rdata = rd;
        end
    end

    // State register; clock enable low freezes everything except reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg       <= '0;
            state_reg.vol   <= {(NUM_CH * NUM_PATH){VOL_UNITY}};
            state_reg.curve <= {2{CURVE_RESET}};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from state flops
    assign reg_rdata   = state_reg.rdata;
    assign out_samples = state_reg.slot[0];
    assign out_valid   = state_reg.valid;
    assign sig_detect  = state_reg.det;
    assign wseq_start  = state_reg.wseq;

endmodule : sdrc_core

/* sdrc_core_sva.sv */
// Port-level assertions for the stereo range control block
`timescale 1ns/1ps

module sdrc_core_sva (
    input logic                         sys_clk,
    input logic                         rst_n,
    input logic                         ce,
    input logic [15:0]                  reg_addr,
    input logic                         reg_rd,
    input logic [15:0]                  reg_rdata,
    input sdrc_pkg::sdrc_rate_e         effects_sample_rate,
    input logic [sdrc_pkg::FRAME_W-1:0] out_samples,
    input logic                         out_valid,
    input logic                         out_ready,
    input logic [1:0]                   sig_detect,
    input logic                         wseq_start
);
    import sdrc_pkg::*;

    logic mapped;

    // Decoded register space; any other read must come back as zero
    assign mapped = (reg_addr >= ADDR_MIX_FIRST && reg_addr <= ADDR_MIX_LAST)
        || reg_addr == ADDR_FX_STATUS
        || (reg_addr >= ADDR_P1_CTRL_A && reg_addr <= ADDR_P1_CTRL_A + OFS_EXPAND)
        || (reg_addr >= ADDR_P2_CTRL_A && reg_addr <= ADDR_P2_CTRL_A + OFS_EXPAND);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Register reads
    property p_unmapped_zero;
        reg_rd && ce && !mapped |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
    property p_one_reserved;
        reg_rd && ce && reg_addr == ADDR_P1_CTRL_A |=> reg_rdata[15:5] == 11'h000;
    endproperty
    a_one_reserved: assert property (p_one_reserved) else $error("ctrl one spare bits");
    property p_two_reserved;
        reg_rd && ce && reg_addr == ADDR_P2_CTRL_A |=> reg_rdata[15:4] == 12'h000;
    endproperty
    a_two_reserved: assert property (p_two_reserved) else $error("ctrl two spare bits");
    // Top rate means nothing is really running, whatever is stored
    property p_status_bits;
        reg_rd && ce && reg_addr == ADDR_FX_STATUS |=> (reg_rdata &
            (($past(effects_sample_rate) == SDRC_RATE_192K) ? 16'hFFFF : 16'hF0FF)) == 16'h0000;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits");

    // Stream and event outputs
    property p_stall_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_samples);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stalled frame moved");
    property p_wseq_rise;
        wseq_start |-> sig_detect[0] && !$past(sig_detect[0]);
    endproperty
    a_wseq_rise: assert property (p_wseq_rise) else $error("trigger without rise");
    property p_wseq_pulse;
        wseq_start |=> !wseq_start;
    endproperty
    a_wseq_pulse: assert property (p_wseq_pulse) else $error("trigger too long");
    property p_ce_freeze;
        !ce |=> $stable(out_valid) && $stable(out_samples) && $stable(sig_detect);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("moved while frozen");
    // Not disabled by reset, since it is about reset itself
    property p_reset_clear;
        disable iff (1'b0)
        !rst_n && ce |=> reg_rdata == 16'h0000 && !out_valid && sig_detect == 2'b00 && !wseq_start;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state");
endmodule : sdrc_core_sva

bind sdrc_core sdrc_core_sva u_sva (.sys_clk, .rst_n, .ce, .reg_addr, .reg_rd, .reg_rdata,
    .effects_sample_rate, .out_samples, .out_valid, .out_ready, .sig_detect, .wseq_start);

/* sdrc_pkg.sv */
// Constants, field layouts and types of the stereo range control block
package sdrc_pkg;

    // Geometry of the mixers feeding the four processor input channels
    localparam int NUM_CH    = 4;
    localparam int NUM_PATH  = 4;
    localparam int SAMPLE_W  = 16;
    localparam int VOL_W     = 8;
    localparam int SEL_W     = 7;
    localparam int LVL_W     = 8;
    localparam int SLOPE_W   = 6;
    localparam int VOL_FRAC  = 7;
    localparam int SLOPE_FRAC = 4;
    localparam int FRAME_W   = NUM_CH * SAMPLE_W;

    // Register addresses
    localparam logic [15:0] ADDR_MIX_FIRST = 16'h08C0;
    localparam logic [15:0] ADDR_MIX_LAST  = 16'h08DF;
    localparam logic [15:0] ADDR_FX_STATUS = 16'h0E01;
    localparam logic [15:0] ADDR_P1_CTRL_A = 16'h0E80;
    localparam logic [15:0] ADDR_P2_CTRL_A = 16'h0E89;
    localparam logic [15:0] OFS_KNEE1      = 16'h0001;
    localparam logic [15:0] OFS_SLOPES     = 16'h0002;
    localparam logic [15:0] OFS_KNEE2      = 16'h0003;
    localparam logic [15:0] OFS_EXPAND     = 16'h0004;

    // Control word bit positions
    localparam int BIT_RIGHT_EN    = 0;
    localparam int BIT_LEFT_EN     = 1;
    localparam int BIT_GATE_EN     = 2;
    localparam int BIT_KNEE2_OP_EN = 3;
    localparam int BIT_WSEQ_EN     = 4;
    localparam int STS_LSB         = 8;

    // Reset values
    localparam logic [VOL_W-1:0]   VOL_UNITY   = 8'h80;
    localparam logic [SLOPE_W-1:0] SLOPE_UNITY = 6'h10;

    // Level estimate and detection, in whole dB
    localparam int DB_PER_BIT = 6;
    localparam int SILENT_DB  = -96;
    localparam int DETECT_DB  = -30;
    localparam int GAIN_LIMIT_DB = 90;

    // Timing
    localparam int CLK_HZ      = 40_000_000;
    localparam int BASE_RATE_HZ = 8_000;
    localparam int DIV_BASE    = CLK_HZ / BASE_RATE_HZ;

    typedef enum logic [2:0] {
        SDRC_RATE_8K,
        SDRC_RATE_16K,
        SDRC_RATE_32K,
        SDRC_RATE_48K,
        SDRC_RATE_96K,
        SDRC_RATE_192K
    } sdrc_rate_e;

    typedef struct packed {
        logic [LVL_W-1:0]   knee_ip;
        logic [LVL_W-1:0]   knee_op;
        logic [SLOPE_W-1:0] hi_slope;
        logic [SLOPE_W-1:0] lo_slope;
        logic [LVL_W-1:0]   knee2_ip;
        logic [LVL_W-1:0]   knee2_op;
        logic [SLOPE_W-1:0] exp_slope;
        logic               gate_en;
        logic               knee2_op_en;
    } sdrc_curve_s;

    localparam sdrc_curve_s CURVE_RESET = '{
        knee_ip: '0, knee_op: '0, hi_slope: SLOPE_UNITY, lo_slope: SLOPE_UNITY,
        knee2_ip: '0, knee2_op: '0, exp_slope: SLOPE_UNITY,
        gate_en: 1'b0, knee2_op_en: 1'b0
    };

endpackage : sdrc_pkg

/* sdrc_sink.sv */
// Stream consumer model standing for the mixing and routing engine
`timescale 1ns/1ps

module sdrc_sink (
    input  logic                         sys_clk,
    input  logic                         rst_n,
    input  logic                         ce,
    input  logic                         stall,
    input  logic                         slow,
    input  logic [sdrc_pkg::FRAME_W-1:0] out_samples,
    input  logic                         out_valid,
    output logic                         out_ready,
    output logic [sdrc_pkg::FRAME_W-1:0] last_frame,
    output logic [15:0]                  n_taken
);
    import sdrc_pkg::*;

    logic phase_reg;

    // Same clock and rate as the block, so no rate converter is needed
    // Slow mode only accepts every other cycle, to keep the buffer busy
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_reg  <= 1'b0;
            out_ready  <= 1'b0;
            last_frame <= '0;
            n_taken    <= 16'h0000;
        end else begin
            phase_reg <= ~phase_reg;
            out_ready <= !stall && (!slow || phase_reg);
            if (out_valid && out_ready && ce) begin
                last_frame <= out_samples;
                n_taken    <= n_taken + 16'h0001;
            end
        end
    end
endmodule : sdrc_sink

/* stereo_dynamic_range_control_test.sv */
// Self-checking bench of the range control block and its consumer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module stereo_dynamic_range_control_test;
    import sdrc_pkg::*;

    typedef struct {logic [15:0] k1, sl, k2, ex, ctl, smp, res; logic det;} sdrc_row_s;
    logic              sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0, slow = 1'b0;
    logic [15:0]       reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    sdrc_rate_e        effects_sample_rate = SDRC_RATE_8K;
    logic [15:0][15:0] src_samples = '0;
    logic [3:0][15:0]  out_samples, last_frame;
    logic              out_valid, out_ready, wseq_start;
    logic [1:0]        sig_detect;
    logic [15:0]       n_taken;
    int                err_count = 0, n_compared = 0;
    // Rows: knee1, slopes, knee2, expand, control, in, out, detect
    sdrc_row_s rows [8] = '{
        '{16'h0000, 16'h0410, 16'h0000, 16'h0010, 16'h0002, 16'h4000, 16'h4000, 1'b1},
        '{16'h00EE, 16'h0400, 16'h0000, 16'h0010, 16'h0002, 16'h4000, 16'h1000, 1'b1},
        '{16'hF4E8, 16'h0210, 16'h0000, 16'h0010, 16'h0002, 16'h4000, 16'h1000, 1'b1},
        '{16'h000C, 16'h0410, 16'h0000, 16'h0010, 16'h0002, 16'h0100, 16'h0400, 1'b0},
        '{16'h0000, 16'h0410, 16'hE200, 16'h0020, 16'h0006, 16'h0100, 16'h0040, 1'b0},
        '{16'h0000, 16'h0410, 16'hE2D6, 16'h0020, 16'h000E, 16'h0100, 16'h0010, 1'b0},
        '{16'h0000, 16'h0410, 16'hE2D6, 16'h0020, 16'h0002, 16'h0100, 16'h0100, 1'b0},
        '{16'h0000, 16'h0410, 16'h0000, 16'h0010, 16'h0000, 16'h4000, 16'h0000, 1'b0}};

    // Small divider keeps a sample period at 48 cycles
    sdrc_core #(.DIV_BASE(48)) u_dut (.sys_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .effects_sample_rate, .src_samples, .out_samples, .out_valid,
        .out_ready, .sig_detect, .wseq_start);
    sdrc_sink u_sink (.sys_clk, .rst_n, .ce, .stall, .slow, .out_samples, .out_valid,
        .out_ready, .last_frame, .n_taken);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // One-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [15:0] a, d);
        @(negedge sys_clk) begin reg_addr = a; reg_wdata = d; reg_wr = 1'b1; end
        @(negedge sys_clk) reg_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, e);
        @(negedge sys_clk) begin reg_addr = a; reg_rd = 1'b1; end
        @(negedge sys_clk) reg_rd = 1'b0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd_chk
    // Second frame taken surely saw the new settings
    task automatic frame(input int n);
        logic [15:0] n0;
        n0 = n_taken;
        for (int k = 0; k < 900 && n_taken < n0 + 16'(n); k++) @(negedge sys_clk);
        if (n_taken < n0 + 16'(n)) begin `CHK("frame wait", 1'b1, 1'b0) end_of_test(); end
    endtask : frame
    task automatic cfg(input int i);
        wr(ADDR_P1_CTRL_A + OFS_KNEE1, rows[i].k1);
        wr(ADDR_P1_CTRL_A + OFS_SLOPES, rows[i].sl);
        wr(ADDR_P1_CTRL_A + OFS_KNEE2, rows[i].k2);
        wr(ADDR_P1_CTRL_A + OFS_EXPAND, rows[i].ex);
        wr(ADDR_P1_CTRL_A, rows[i].ctl);
    endtask : cfg

    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        wr(16'h08C1, 16'h0001);
        foreach (rows[i]) begin
            cfg(i);
            src_samples[0] = rows[i].smp;
            frame(2);
            `CHK("left one", rows[i].res, last_frame[0])
            `CHK("others", 48'h0, last_frame[3:1])
            `CHK("detect", rows[i].det, sig_detect[0])
            $display("curve row %0d done", i);
        end
        // Two paths summed, then one path at half volume
        cfg(0);
        wr(16'h08C3, 16'h0002);
        src_samples[1] = 16'h2000;
        frame(2);
        `CHK("sum", 16'h6000, last_frame[0])
        wr(16'h08C0, 16'h0040);
        frame(2);
        `CHK("volume", 16'h4000, last_frame[0])
        wr(16'h08C3, 16'h0000);
        // Last mixer slot feeds processor two right; its trigger bit is inert
        wr(ADDR_MIX_LAST, 16'h0001);
        wr(ADDR_P2_CTRL_A, 16'h0011);
        frame(2);
        `CHK("two right", 32'h4000_0000, last_frame[3:2])
        `CHK("two detect", 1'b1, sig_detect[1])
        wr(ADDR_P2_CTRL_A, 16'h0000);
        $display("mixer test done");
        // Sequencer trigger on a rising detect, with a slow consumer
        slow = 1'b1;
        wr(ADDR_P1_CTRL_A, 16'h0012);
        src_samples[0] = 16'h0000;
        frame(2);
        `CHK("quiet", 1'b0, sig_detect[0])
        src_samples[0] = 16'h4000;
        for (int k = 0; k < 400 && wseq_start !== 1'b1; k++) @(posedge sys_clk) #1;
        `CHK("trigger", 1'b1, wseq_start)
        if (wseq_start !== 1'b1) end_of_test();
        $display("trigger test done");
        // Consumer stalls long enough to fill the buffer; the head frame must stay valid and unchanged
        @(negedge sys_clk) stall = 1'b1;
        repeat (200) @(negedge sys_clk);
        `CHK("held valid", 1'b1, out_valid)
        `CHK("held frame", 16'h2000, out_samples[0])
        stall = 1'b0;
        frame(4);
        `CHK("after stall", 16'h2000, last_frame[0])
        $display("stall test done");
        // Every allowed rate runs; top rate only with channels off
        wr(ADDR_P1_CTRL_A, 16'h0002);
        for (int r = 0; r < 5; r++) begin
            effects_sample_rate = sdrc_rate_e'(r);
            rd_chk(ADDR_FX_STATUS, 16'h0100);
        end
        wr(ADDR_P1_CTRL_A, 16'h0000);
        effects_sample_rate = SDRC_RATE_192K;
        rd_chk(ADDR_FX_STATUS, 16'h0000);
        effects_sample_rate = SDRC_RATE_8K;
        // Spare bits, unmapped places and readback of all channels
        wr(ADDR_P1_CTRL_A, 16'hFFFF);
        rd_chk(ADDR_P1_CTRL_A, 16'h001F);
        wr(ADDR_P2_CTRL_A, 16'hFFFF);
        rd_chk(ADDR_P2_CTRL_A, 16'h000F);
        rd_chk(ADDR_FX_STATUS, 16'h0F00);
        wr(16'h0E90, 16'h1234);
        rd_chk(16'h0E90, 16'h0000);
        rd_chk(16'h08BF, 16'h0000);
        $display("register test done");
        // Frozen clock enable, then a second reset mid-run
        ce = 1'b0;
        repeat (50) @(negedge sys_clk);
        ce = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        rd_chk(ADDR_P1_CTRL_A, 16'h0000);
        rd_chk(ADDR_P2_CTRL_A, 16'h0000);
        rd_chk(ADDR_FX_STATUS, 16'h0000);
        rd_chk(ADDR_MIX_FIRST, 16'h0080);
        rd_chk(ADDR_P1_CTRL_A + OFS_SLOPES, 16'h0410);
        $display("reset test done");
        end_of_test();
    end
endmodule : stereo_dynamic_range_control_test
